// ==== lpd_decoder.sv ====
// command and data byte decoder of the lcd and pwm driver
// Summary of operation
// - 01100 sets static levels of pins 0..2
// - 01101 sets static levels of pins 3..5
// - prefix 10 loads the display pointer
// - display pointer advances after each ram write
// - pointer limit follows multiplex mode
// - bad display pointer blocks ram writes
// - 01110 loads pwm channel address 0..5
// - bad pwm address blocks pwm writes
// - data byte stored whole at pointer
// - ram data needs register select 01
// - pwm byte stores seven duty bits
// - pwm data needs register select 10
// - pwm write targets last valid address
// - reset disables display, outputs grounded
// - reset disables outputs, clears duty values
// - reset selects 1:8 mux, quarter bias
// - reset clears both pointers
// - reset leaves display ram untouched
// - after reset clock pin undriven
// - reset sets divider and bit defaults
// - reset pin restores all configuration
module lpd_decoder
   import lpd_pkg::*;
#(
   parameter int FIFO_DEPTH = LPD_FIFO_DEPTH
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic         byte_valid,
   output logic              byte_ready,
   input  wire logic [7:0]   byte_value,
   input  wire logic         byte_is_data,
   input  wire logic [1:0]   register_select,
   input  wire logic         decode_hold,
   input  wire logic         cfg_wr,
   input  wire logic [3:0]   cfg_sel,
   input  wire logic [7:0]   cfg_value,
   input  wire logic [5:0]   disp_rd_addr,
   output logic      [7:0]   disp_rd_data,
   output logic      [5:0]   general_out_pin,
   output logic      [5:0]   general_out_oe,
   output logic      [41:0]  pwm_duty,
   output logic              pwm_invert,
   output logic      [3:0]   pwm_frame_divider,
   output logic      [4:0]   lcd_frame_divider,
   output logic      [1:0]   mux_mode,
   output logic      [1:0]   bias_mode,
   output logic      [3:0]   mode_bits,
   output logic      [2:0]   osc_bits,
   output logic      [11:0]  output_pin_mode,
   output logic              display_enable,
   output logic              drive_ground,
   output logic              clock_pin_o,
   output logic              clock_pin_oe,
   output logic      [5:0]   display_ptr,
   output logic      [2:0]   pwm_address,
   output logic              display_ptr_valid,
   output logic              pwm_address_valid
);

   typedef struct packed {
      logic [5:0]       gpo_level;
      logic [5:0]       disp_ptr;
      logic             disp_ok;
      logic [2:0]       pwm_ptr;
      logic             pwm_ok;
      logic [5:0][6:0]  duty;
      logic             pwm_inv;
      logic [3:0]       pwm_div;
      logic [4:0]       lcd_div;
      logic [1:0]       mux;
      logic [1:0]       bias;
      logic [3:0]       mode;
      logic [2:0]       osc;
      logic [11:0]      pin_mode;
   } lpd_state_type;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [5:0] last_addr(input logic [1:0] mux);
      case (mux)
         LPD_MUX_6: last_addr = LPD_LAST_MUX6;
         LPD_MUX_4: last_addr = LPD_LAST_MUX4;
         default:   last_addr = LPD_LAST_MUX8;
      endcase
   endfunction : last_addr

   function automatic logic [5:0] lpd_reset_pins();
      lpd_reset_pins = '0;
   endfunction : lpd_reset_pins

   lpd_state_type          q;
   lpd_state_type          next_q;
   logic [7:0]             ram [LPD_RAM_DEPTH];
   logic                   f_valid;
   logic [LPD_TAG_W-1:0]   f_data;
   logic                   pop;
   logic [7:0]             cur_byte;
   logic                   cur_data;
   logic [1:0]             cur_rs;
   logic                   ram_we;
   logic                   pwm_we;
   logic [5:0]             static_mask;
   logic [7:0]             rd_data;

   // ---------------------------------------------------------------
   // input buffer
   // ---------------------------------------------------------------
   // holding the decoder lets the fifo fill and push back on the bus side
   lpd_fifo #(
      .WIDTH (LPD_TAG_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (byte_valid),
      .in_ready  (byte_ready),
      .in_data   ({byte_is_data, register_select, byte_value}),
      .out_valid (f_valid),
      .out_ready (!decode_hold),
      .out_data  (f_data)
   );

   assign pop      = f_valid && !decode_hold;
   assign cur_byte = f_data[7:0];
   assign cur_rs   = f_data[9:8];
   assign cur_data = f_data[10];

   assign ram_we = pop && cur_data && (cur_rs == LPD_RS_RAM) && q.disp_ok &&
                   (q.disp_ptr <= last_addr(q.mux));
   assign pwm_we = pop && cur_data && (cur_rs == LPD_RS_PWM) && q.pwm_ok;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      if (pop && !cur_data) begin
         if (cur_byte[7:3] == LPD_OP_GPO_LO) begin
            next_q.gpo_level[2:0] = cur_byte[2:0];
         end else if (cur_byte[7:3] == LPD_OP_GPO_HI) begin
            next_q.gpo_level[5:3] = cur_byte[2:0];
         end else if (cur_byte[7:3] == LPD_OP_PWM_PTR) begin
            // an invalid address keeps the old one but locks writes out
            if (cur_byte[2:0] <= LPD_PWM_LAST) begin
               next_q.pwm_ptr = cur_byte[2:0];
               next_q.pwm_ok  = 1'b1;
            end else begin
               next_q.pwm_ok  = 1'b0;
            end
         end else if (cur_byte[7:6] == LPD_OP_DISP_PTR) begin
            if (cur_byte[5:0] <= last_addr(q.mux)) begin
               next_q.disp_ptr = cur_byte[5:0];
               next_q.disp_ok  = 1'b1;
            end else begin
               next_q.disp_ok  = 1'b0;
            end
         end else if (cur_byte[7:4] == LPD_OP_PWM_FRM) begin
            next_q.pwm_div = cur_byte[3:0];
         end
         // any other pattern falls through untouched
      end
      if (ram_we) begin
         // wrap to the first address after the last one of this mode
         if (q.disp_ptr == last_addr(q.mux)) begin
            next_q.disp_ptr = '0;
         end else begin
            next_q.disp_ptr = q.disp_ptr + 6'h01;
         end
      end
      if (pwm_we) begin
         next_q.duty[q.pwm_ptr] = cur_byte[6:0];
      end
      if (cfg_wr) begin
         case (lpd_cfg_sel_type'(cfg_sel))
            LPD_CFG_MODE:    next_q.mode = cfg_value[3:0];
            LPD_CFG_OSC:     next_q.osc = cfg_value[2:0];
            LPD_CFG_PWMI:    next_q.pwm_inv = cfg_value[0];
            LPD_CFG_MUX:     next_q.mux = cfg_value[1:0];
            LPD_CFG_BIAS:    next_q.bias = cfg_value[1:0];
            LPD_CFG_LCD_DIV: next_q.lcd_div = cfg_value[4:0];
            LPD_CFG_GPM01:   next_q.pin_mode[3:0] = cfg_value[3:0];
            LPD_CFG_GPM23:   next_q.pin_mode[7:4] = cfg_value[3:0];
            LPD_CFG_GPM45:   next_q.pin_mode[11:8] = cfg_value[3:0];
            default:         next_q.mode = q.mode;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q         <= '0;
         q.lcd_div <= LPD_RST_LCD_DIV;
         q.pwm_div <= LPD_RST_PWM_DIV;
         q.disp_ok <= 1'b1;
         q.pwm_ok  <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ram has no reset so a reset pin keeps the picture
   always_ff @(posedge core_clk) begin
      if (ram_we) begin
         ram[q.disp_ptr] <= cur_byte;
      end
      rd_data <= (disp_rd_addr < 6'(LPD_RAM_DEPTH)) ? ram[disp_rd_addr] : 8'h00;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   generate
      for (genvar i = 0; i < LPD_CHANNELS; i++) begin : g_pin
         assign static_mask[i]     = (q.pin_mode[2*i+1:2*i] == LPD_PIN_STATIC);
         assign general_out_oe[i]  = (q.pin_mode[2*i+1:2*i] != 2'h0);
         assign pwm_duty[7*i+6:7*i] = q.duty[i];
      end
   endgenerate

   assign general_out_pin   = static_mask & q.gpo_level;
   assign disp_rd_data      = rst ? 8'h00 : rd_data;
   assign pwm_invert        = q.pwm_inv;
   assign pwm_frame_divider = q.pwm_div;
   assign lcd_frame_divider = q.lcd_div;
   assign mux_mode          = q.mux;
   assign bias_mode         = q.bias;
   assign mode_bits         = q.mode;
   assign osc_bits          = q.osc;
   assign output_pin_mode   = q.pin_mode;
   assign display_enable    = q.mode[0];
   assign drive_ground      = !q.mode[0];
   assign clock_pin_o       = 1'b0;
   assign clock_pin_oe      = 1'b0;
   assign display_ptr       = q.disp_ptr;
   assign pwm_address       = q.pwm_ptr;
   assign display_ptr_valid = q.disp_ok;
   assign pwm_address_valid = q.pwm_ok;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic       chk_we;
   logic [2:0] chk_ch;
   logic [6:0] chk_val;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chk_we  <= 1'b0;
         chk_ch  <= 3'h0;
         chk_val <= 7'h00;
      end else begin
         chk_we  <= pwm_we;
         chk_ch  <= q.pwm_ptr;
         chk_val <= cur_byte[6:0];
      end
   end

   AST_GPO_LO: assert property (
      pop && !cur_data && cur_byte[7:3] == LPD_OP_GPO_LO && static_mask[0]
      |=> general_out_pin[0] == $past(cur_byte[0]))
      else $error("static level of pin 0 not taken");
   AST_GPO_HI: assert property (
      pop && !cur_data && cur_byte[7:3] == LPD_OP_GPO_HI
      |=> q.gpo_level[5:3] == $past(cur_byte[2:0]))
      else $error("static levels of pins 3..5 not taken");
   AST_DPTR_LOAD: assert property (
      pop && !cur_data && cur_byte[7:6] == LPD_OP_DISP_PTR &&
      cur_byte[5:0] <= last_addr(q.mux)
      |=> display_ptr == $past(cur_byte[5:0]) && display_ptr_valid)
      else $error("valid display pointer not loaded");
   AST_DPTR_INC: assert property (
      ram_we && q.disp_ptr < last_addr(q.mux) && !cfg_wr
      |=> display_ptr == $past(q.disp_ptr) + 6'h01)
      else $error("display pointer did not advance");
   AST_DPTR_BAD: assert property (
      pop && !cur_data && cur_byte[7:6] == LPD_OP_DISP_PTR &&
      cur_byte[5:0] > last_addr(q.mux)
      |=> !display_ptr_valid && display_ptr == $past(q.disp_ptr))
      else $error("bad display pointer accepted");
   AST_NO_RAM_WR: assert property (
      ram_we |-> q.disp_ok && cur_rs == LPD_RS_RAM)
      else $error("ram written without valid pointer or select");
   AST_PPTR_BAD: assert property (
      pop && !cur_data && cur_byte[7:3] == LPD_OP_PWM_PTR && cur_byte[2:0] > LPD_PWM_LAST
      |=> !pwm_address_valid ##0 !pwm_we)
      else $error("bad pwm address accepted");
   AST_PWM_WR: assert property (
      chk_we |-> pwm_duty[7*chk_ch +: 7] == chk_val)
      else $error("duty not stored in selected channel");
   AST_PWM_RS: assert property (
      pwm_we |-> cur_rs == LPD_RS_PWM && cur_data)
      else $error("pwm written without select 10");
   AST_RESET_VAL: assert property (disable iff (1'b0)
      $fell(rst) |-> pwm_duty == '0 && mux_mode == LPD_MUX_8 &&
      bias_mode == 2'h0 && display_ptr == 6'h00 && pwm_address == 3'h0 &&
      lcd_frame_divider == LPD_RST_LCD_DIV && pwm_frame_divider == LPD_RST_PWM_DIV &&
      general_out_oe == lpd_reset_pins() && drive_ground && !clock_pin_oe)
      else $error("reset defaults wrong");

   // pointer and data paths seen from the outputs, the ram array and gpo_level
   AST_PPTR_LOAD: assert property (
      pop && !cur_data && cur_byte[7:3] == LPD_OP_PWM_PTR && cur_byte[2:0] <= LPD_PWM_LAST
      |=> pwm_address == $past(cur_byte[2:0]) && pwm_address_valid)
      else $error("valid pwm address not loaded");
   AST_PPTR_HOLD: assert property (
      pwm_we |=> pwm_address == $past(pwm_address))
      else $error("pwm address moved on a data write");
   AST_RAM_DATA: assert property (
      ram_we |=> ram[$past(q.disp_ptr)] == $past(cur_byte))
      else $error("ram byte not stored at pointer");
   AST_RAM_SEL: assert property (
      pop && cur_data && cur_rs != LPD_RS_RAM |=> display_ptr == $past(display_ptr))
      else $error("display pointer moved without select 01");
   AST_RAM_RANGE: assert property (
      ram_we |-> display_ptr <= last_addr(mux_mode))
      else $error("ram written beyond the mode limit");
   AST_UNKNOWN_CMD: assert property (
      pop && !cur_data && cur_byte[7:6] == 2'h3
      |=> q.gpo_level == $past(q.gpo_level) && display_ptr == $past(display_ptr) &&
      pwm_address == $past(pwm_address) && pwm_duty == $past(pwm_duty))
      else $error("unknown command changed state");

   COV_RAM_WR:   cover property (ram_we ##1 ram_we);
   COV_PWM_WR:   cover property (pwm_we);
   COV_BAD_DPTR: cover property (pop && !cur_data && cur_byte[7:6] == LPD_OP_DISP_PTR &&
                                 cur_byte[5:0] > last_addr(q.mux));
   COV_FULL:     cover property (!byte_ready);
   COV_BAD_PPTR: cover property (pop && !cur_data && cur_byte[7:3] == LPD_OP_PWM_PTR &&
                                 cur_byte[2:0] > LPD_PWM_LAST);

endmodule : lpd_decoder

// ==== lpd_pkg.sv ====
// shared constants and types of the lcd/pwm command decoder
package lpd_pkg;

   // ---------------------------------------------------------------
   // command prefixes
   // ---------------------------------------------------------------
   localparam logic [4:0] LPD_OP_GPO_LO   = 5'h0C;  // 01100
   localparam logic [4:0] LPD_OP_GPO_HI   = 5'h0D;  // 01101
   localparam logic [4:0] LPD_OP_PWM_PTR  = 5'h0E;  // 01110
   localparam logic [1:0] LPD_OP_DISP_PTR = 2'h2;   // 10
   localparam logic [3:0] LPD_OP_PWM_FRM  = 4'h4;   // 0100

   // ---------------------------------------------------------------
   // register select of the control byte
   // ---------------------------------------------------------------
   localparam logic [1:0] LPD_RS_RAM = 2'h1;
   localparam logic [1:0] LPD_RS_PWM = 2'h2;

   // ---------------------------------------------------------------
   // sizes, limits and modes
   // ---------------------------------------------------------------
   localparam int         LPD_CHANNELS   = 6;
   localparam int         LPD_RAM_DEPTH  = 44;
   localparam logic [2:0] LPD_PWM_LAST   = 3'h5;
   localparam logic [5:0] LPD_LAST_MUX8  = 6'h27;  // 39
   localparam logic [5:0] LPD_LAST_MUX6  = 6'h29;  // 41
   localparam logic [5:0] LPD_LAST_MUX4  = 6'h2B;  // 43
   localparam logic [1:0] LPD_MUX_8      = 2'h0;
   localparam logic [1:0] LPD_MUX_6      = 2'h1;
   localparam logic [1:0] LPD_MUX_4      = 2'h2;
   localparam logic [1:0] LPD_PIN_STATIC = 2'h1;
   localparam int         LPD_FIFO_DEPTH = 16;
   localparam int         LPD_TAG_W      = 11;     // is_data, rs, byte

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [4:0] LPD_RST_LCD_DIV = 5'h0E;
   localparam logic [3:0] LPD_RST_PWM_DIV = 4'h7;

   // ---------------------------------------------------------------
   // selectors of the configuration load port
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      LPD_CFG_MODE, LPD_CFG_OSC, LPD_CFG_PWMI, LPD_CFG_MUX, LPD_CFG_BIAS,
      LPD_CFG_LCD_DIV, LPD_CFG_GPM01, LPD_CFG_GPM23, LPD_CFG_GPM45
   } lpd_cfg_sel_type;

endpackage : lpd_pkg

// ==== lpd_fifo.sv ====
// byte fifo in front of the command decoder
module lpd_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } lpd_fifo_state_type;

   lpd_fifo_state_type q;
   lpd_fifo_state_type next_q;
   logic [WIDTH-1:0]   mem [DEPTH];
   logic               push;
   logic               pop;
   logic               full;
   logic               empty;

   assign empty     = (q.wr_ptr == q.rd_ptr);
   assign full      = (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]) &&
                      (q.wr_ptr[AW] != q.rd_ptr[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem[q.rd_ptr[AW-1:0]];

   always_comb begin
      next_q = q;
      if (push) begin
         next_q.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_q.rd_ptr = q.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // storage is not reset; contents only matter once written
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[q.wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule : lpd_fifo

// ==== lpd_host_model.sv ====
// host side model that offers command and data bytes to the decoder
module lpd_host_model (
   input  wire logic       core_clk,
   input  wire logic       byte_ready,
   output logic            byte_valid,
   output logic      [7:0] byte_value,
   output logic            byte_is_data,
   output logic      [1:0] register_select
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      byte_valid      = 1'b0;
      byte_value      = 8'h00;
      byte_is_data    = 1'b0;
      register_select = 2'h0;
   end

   // offer one byte; returns at the taking edge so bursts run one per cycle
   task automatic send(input logic [7:0] b, input logic d, input logic [1:0] rs,
                       output bit ok);
      ok = 1'b0;
      @(negedge core_clk);
      byte_valid      = 1'b1;
      byte_value      = b;
      byte_is_data    = d;
      register_select = rs;
      for (int n = 0; n < 50; n++) begin
         if (byte_ready === 1'b1) begin
            @(posedge core_clk);
            ok = 1'b1;
            break;
         end
         @(negedge core_clk);
      end
   endtask : send

   // released byte and select lines show the inverse so a stale byte cannot pass for a fresh one
   task automatic idle(input int gap);
      @(negedge core_clk);
      byte_valid      = 1'b0;
      byte_value      = ~byte_value;
      register_select = ~register_select;
      repeat (gap) @(negedge core_clk);
   endtask : idle

endmodule : lpd_host_model

// ==== lcd_pwm_data_command_decoder_bench.sv ====
// self-checking bench of the lcd/pwm command decoder
module lcd_pwm_data_command_decoder_bench;
   import lpd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk, rst, byte_valid, byte_ready, byte_is_data, decode_hold, cfg_wr;
   logic [7:0] byte_value, cfg_value, disp_rd_data;
   logic [1:0] register_select, mux_mode, bias_mode;
   logic [3:0] cfg_sel, pwm_frame_divider, mode_bits;
   logic [5:0] disp_rd_addr, general_out_pin, general_out_oe, display_ptr;
   logic [41:0] pwm_duty, duty_exp;
   logic [4:0] lcd_frame_divider;
   logic [2:0] osc_bits, pwm_address;
   logic [11:0] output_pin_mode;
   logic pwm_invert, display_enable, drive_ground, clock_pin_o, clock_pin_oe;
   logic display_ptr_valid, pwm_address_valid;
   int fails = 0;
   int samples_checked = 0;
   logic [5:0] last_tab [3] = '{LPD_LAST_MUX8, LPD_LAST_MUX6, LPD_LAST_MUX4};
   logic [1:0] mode_tab [3] = '{LPD_MUX_8, LPD_MUX_6, LPD_MUX_4};

   lpd_decoder #(.FIFO_DEPTH(16)) u_dut (.core_clk, .rst, .byte_valid, .byte_ready,
      .byte_value, .byte_is_data, .register_select, .decode_hold, .cfg_wr, .cfg_sel,
      .cfg_value, .disp_rd_addr, .disp_rd_data, .general_out_pin, .general_out_oe,
      .pwm_duty, .pwm_invert, .pwm_frame_divider, .lcd_frame_divider, .mux_mode,
      .bias_mode, .mode_bits, .osc_bits, .output_pin_mode, .display_enable, .drive_ground,
      .clock_pin_o, .clock_pin_oe, .display_ptr, .pwm_address, .display_ptr_valid,
      .pwm_address_valid);

   lpd_host_model u_host (.core_clk, .byte_ready, .byte_valid, .byte_value, .byte_is_data,
      .register_select);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [41:0] exp, input logic [41:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // read data is registered: one edge between address and sample
   task automatic chk_ram(input logic [5:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      disp_rd_addr = a;
      @(negedge core_clk);
      chk($sformatf("ram[%0d]", a), {34'h0, exp}, {34'h0, disp_rd_data});
   endtask : chk_ram

   task automatic put(input logic [7:0] b, input logic d, input logic [1:0] rs);
      bit ok;
      u_host.send(b, d, rs, ok);
      if (!ok) begin
         fails++;
         $display("[FAIL] byte_ready expected 1 seen 0");
         give_verdict();
      end
   endtask : put

   task automatic settle();
      u_host.idle(3);
   endtask : settle

   task automatic cfg(input logic [3:0] sel, input logic [7:0] v);
      @(negedge core_clk);
      cfg_wr    = 1'b1;
      cfg_sel   = sel;
      cfg_value = v;
      @(negedge core_clk);
      cfg_wr    = 1'b0;
   endtask : cfg

   task automatic check_defaults();
      chk("display_enable", 0, display_enable);
      chk("drive_ground", 1, drive_ground);
      chk("general_out_oe", 0, general_out_oe);
      chk("pwm_duty", 0, pwm_duty);
      chk("mux_mode", 0, mux_mode);
      chk("bias_mode", 0, bias_mode);
      chk("display_ptr", 0, display_ptr);
      chk("pwm_address", 0, pwm_address);
      chk("clock_pin", 0, {clock_pin_o, clock_pin_oe});
      chk("ptr valid", 2'h3, {display_ptr_valid, pwm_address_valid});
      chk("lcd_frame_divider", 5'h0E, lcd_frame_divider);
      chk("pwm_frame_divider", 4'h7, pwm_frame_divider);
      chk("cfg bits", 0, {mode_bits, osc_bits, output_pin_mode, pwm_invert});
   endtask : check_defaults

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, decode_hold, cfg_wr, cfg_sel, cfg_value, disp_rd_addr} = {1'b1, 20'h0};
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      check_defaults();
      $display("test reset_defaults done");

      cfg(LPD_CFG_GPM01, 8'h05);
      cfg(LPD_CFG_GPM23, 8'h05);
      cfg(LPD_CFG_GPM45, 8'h05);
      put(8'h65, 1'b0, 2'h0);
      put(8'h6B, 1'b0, 2'h0);
      settle();
      chk("general_out_pin", 6'h1D, general_out_pin);
      chk("general_out_oe", 6'h3F, general_out_oe);
      $display("test static_levels done");

      put(8'hA6, 1'b0, 2'h0);
      put(8'h11, 1'b1, LPD_RS_RAM);
      put(8'h22, 1'b1, LPD_RS_RAM);
      settle();
      chk("display_ptr", 0, display_ptr);
      chk_ram(6'd38, 8'h11);
      chk_ram(6'd39, 8'h22);
      for (int i = 0; i < 3; i++) begin
         cfg(LPD_CFG_MUX, {6'h0, mode_tab[i]});
         put({2'b10, last_tab[i]}, 1'b0, 2'h0);
         settle();
         chk("display_ptr_valid", 1, display_ptr_valid);
         put({2'b10, last_tab[i] + 6'h1}, 1'b0, 2'h0);
         settle();
         chk("display_ptr_valid", 0, display_ptr_valid);
         chk("display_ptr", last_tab[i], display_ptr);
      end
      put(8'hC3, 1'b1, LPD_RS_RAM);
      settle();
      chk("display_ptr", 6'd43, display_ptr);
      put(8'hA8, 1'b0, 2'h0);
      put(8'h5A, 1'b1, LPD_RS_RAM);
      put(8'h5B, 1'b1, LPD_RS_RAM);
      put(8'h77, 1'b1, LPD_RS_PWM);
      put(8'h66, 1'b1, 2'h0);
      settle();
      chk("display_ptr", 6'd42, display_ptr);
      cfg(LPD_CFG_MUX, {6'h0, LPD_MUX_8});
      put(8'hA9, 1'b0, 2'h0);
      put(8'hC3, 1'b1, LPD_RS_RAM);
      settle();
      chk("display_ptr", 6'd42, display_ptr);
      chk_ram(6'd40, 8'h5A);
      chk_ram(6'd41, 8'h5B);
      $display("test display_pointer done");

      duty_exp = '0;
      for (int c = 0; c < LPD_CHANNELS; c++) begin
         put(8'h70 | 8'(c), 1'b0, 2'h0);
         put(8'h80 | 8'(8'h11 * c), 1'b1, LPD_RS_PWM);
         duty_exp[7*c +: 7] = 7'(8'h11 * c);
      end
      settle();
      chk("pwm_duty", duty_exp, pwm_duty);
      put(8'h76, 1'b0, 2'h0);
      put(8'h7F, 1'b1, LPD_RS_PWM);
      settle();
      chk("pwm_address_valid", 0, pwm_address_valid);
      chk("pwm_duty", duty_exp, pwm_duty);
      put(8'h73, 1'b0, 2'h0);
      put(8'h01, 1'b1, LPD_RS_PWM);
      put(8'h02, 1'b1, LPD_RS_PWM);
      put(8'h55, 1'b1, LPD_RS_RAM);
      put(8'hC0, 1'b0, 2'h0);
      settle();
      duty_exp[21 +: 7] = 7'h02;
      chk("pwm_duty", duty_exp, pwm_duty);
      chk("pwm_address", 3, pwm_address);
      chk("state", {6'h1D, 6'd42}, {general_out_pin, display_ptr});
      $display("test pwm_channels done");

      cfg(LPD_CFG_MUX, {6'h0, LPD_MUX_4});
      put(8'hA0, 1'b0, 2'h0);
      settle();
      decode_hold = 1'b1;
      for (int i = 0; i < LPD_FIFO_DEPTH; i++) put(8'hD0 + 8'(i), 1'b1, LPD_RS_RAM);
      u_host.idle(0);
      chk("byte_ready", 0, byte_ready);
      chk("display_ptr", 6'd32, display_ptr);
      decode_hold = 1'b0;
      repeat (20) @(negedge core_clk);
      chk("display_ptr", 6'd4, display_ptr);
      chk_ram(6'd43, 8'hDB);
      chk_ram(6'd3, 8'hDF);
      chk_ram(6'd50, 8'h00);
      $display("test buffer_fill done");

      cfg(LPD_CFG_MODE, 8'h01);
      cfg(LPD_CFG_OSC, 8'h05);
      cfg(LPD_CFG_PWMI, 8'h01);
      cfg(LPD_CFG_BIAS, 8'h02);
      cfg(LPD_CFG_LCD_DIV, 8'h13);
      cfg(4'hF, 8'hFF);
      put(8'h4B, 1'b0, 2'h0);
      settle();
      chk("display", 2'h2, {display_enable, drive_ground});
      chk("mode osc inv", {4'h1, 3'h5, 1'b1}, {mode_bits, osc_bits, pwm_invert});
      chk("dividers", {2'h2,5'h13,4'hB}, {bias_mode,lcd_frame_divider,pwm_frame_divider});
      $display("test config_fields done");

      @(negedge core_clk);
      rst = 1'b1;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      check_defaults();
      chk_ram(6'd40, 8'hD8);
      $display("test mid_run_reset done");
      give_verdict();
   end

endmodule : lcd_pwm_data_command_decoder_bench
